// File: rtl/ptps_node.sv
// Purpose: node logic wrapping space packets for the link and spreading time
// Assumes: link tx/rx streams, timecodes and upper layer share this clock
// Notes:   delivered bytes have no back-pressure; the upper layer takes each one
// Notes on behaviour
// R1: send each packet once, no ack/retry/segmenting
// R2: no remote memory access, packets and time only
// R3: payload is always a space packet
// R4: prefix path and logical address, then send
// R5: hand unwrapped space packets to upper layer
// R6: time digits use unsegmented time code
// R7: time packet holds value at next zero
// R8: load held time at timecode zero or command
// R9: master sends one time packet per target
// R10: newer time packet replaces the pending one
module ptps_node
  import ptps_pkg::*;
#(
  parameter int N_TARGETS = 2   // time packet receivers served by the master
)(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        arst_n,
  // upper layer send side
  input  wire logic                        send_valid,
  input  wire ptps_req_type                send_req,
  input  wire ptps_byte_type               src,
  output logic                             src_ready,
  output logic                             send_busy,
  // link transmit stream
  output ptps_byte_type                    tx,
  input  wire logic                        tx_ready,
  // link receive stream and timecodes
  input  wire ptps_byte_type               rx,
  input  wire logic                        tc_valid,
  input  wire logic [5:0]                  tc_value,
  // upper layer receive side
  output ptps_byte_type                    dlv,
  // time service
  input  wire logic                        dist_start,
  input  wire logic [N_TARGETS-1:0][7:0]   targets,
  input  wire logic                        apply_now,
  output logic [47:0]                      time_now,
  output logic                             time_pending
);
  ptps_state_type s;        // registered state
  ptps_state_type next_s;   // value for the next edge
  logic           free;     // transmit slot can take a byte
  logic           tc_zero;  // timecode wrapped to zero
  logic           rx_cap;   // a complete time packet arrived
  logic [47:0]    cuc_in;   // time bytes shifted with the current one

  // byte of the time packet body at a given index
  function automatic logic [7:0] time_byte(input logic [3:0] idx, input logic [47:0] cuc);
    logic [7:0] b;
    b = 8'h00;
    case (idx)
      4'h0:    b = {5'h00, TIME_APID[10:8]};
      4'h1:    b = TIME_APID[7:0];
      4'h2:    b = SP_SEQ_HI;
      4'h3:    b = 8'h00;
      4'h4:    b = SP_LEN_FIELD[15:8];
      4'h5:    b = SP_LEN_FIELD[7:0];
      default: b = cuc[8*(TIME_BYTES-1-int'(idx)) +: 8]; // R6
    endcase
    return b;
  endfunction

  assign free    = !s.tx.valid || tx_ready;
  assign tc_zero = tc_valid && (tc_value == TC_ZERO);
  assign cuc_in  = {s.rx_cuc[39:0], rx.data};
  assign rx_cap  = rx.valid && rx.last && s.rx_keep && s.apid_ok
                   && (s.rx_idx == RX_IDX_LAST);

  // next state: transmit framing, receive unwrapping, time keeping
  always_comb
  begin
    next_s = s;
    next_s.tx.valid = s.tx.valid && !tx_ready;
    next_s.dlv = '0;
    case (s.st)
      ST_IDLE:
      begin
        // time packets go first; a send waits while busy is shown
        if (s.dist_act)
        begin
          next_s.is_time = 1'b1;
          next_s.req.laddr = targets[s.tgt];                  // R9
          next_s.st = ST_ADDR;
        end
        else if (send_valid)
        begin
          next_s.is_time = 1'b0;
          next_s.req = send_req;                              // R4
          next_s.pidx = 3'h0;
          next_s.st = (send_req.path_len != 3'h0) ? ST_PATH : ST_ADDR;
        end
      end
      ST_PATH:
      begin
        if (free)
        begin
          next_s.tx = '{valid: 1'b1, last: 1'b0, data: s.req.path[s.pidx]}; // R4
          next_s.pidx = s.pidx + 3'h1;
          if (s.pidx + 3'h1 == s.req.path_len)
            next_s.st = ST_ADDR;
        end
      end
      ST_ADDR:
      begin
        if (free)
        begin
          next_s.tx = '{valid: 1'b1, last: 1'b0, data: s.req.laddr}; // R4
          next_s.st = ST_PID;
        end
      end
      ST_PID:
      begin
        // only the packet transfer protocol byte is ever sent
        if (free)
        begin
          next_s.tx = '{valid: 1'b1, last: 1'b0, data: PTP_PID}; // R2
          next_s.tidx = 4'h0;
          next_s.st = s.is_time ? ST_TIME : ST_BODY;
        end
      end
      ST_BODY:
      begin
        // space packet bytes pass through once, unchanged and unsplit
        if (s.src_ready && src.valid)
        begin
          next_s.tx = '{valid: 1'b1, last: src.last, data: src.data}; // R1
          if (src.last)
            next_s.st = ST_IDLE;                              // R1
        end
      end
      ST_TIME:
      begin
        if (free)
        begin
          next_s.tx.valid = 1'b1;
          next_s.tx.data = time_byte(s.tidx, s.frame);        // R3
          next_s.tx.last = (s.tidx == 4'(TIME_BYTES - 1));
          next_s.tidx = s.tidx + 4'h1;
          if (s.tidx == 4'(TIME_BYTES - 1))
          begin
            // one separate packet per target, then done
            next_s.st = ST_IDLE;
            if (s.tgt == 8'(N_TARGETS - 1))                   // R9
            begin
              next_s.dist_act = 1'b0;
              next_s.tgt = 8'h00;
            end
            else
              next_s.tgt = s.tgt + 8'h01;                     // R9
          end
        end
      end
      default:
        next_s.st = ST_IDLE;
    endcase
    // start of a distribution round latches the value at next zero
    if (dist_start && !s.dist_act)
    begin
      next_s.dist_act = 1'b1;
      next_s.tgt = 8'h00;
      next_s.frame = s.time_reg + TIME_STEP;                  // R7
    end
    // ready only toward an empty slot, so no byte is dropped
    next_s.src_ready = (next_s.st == ST_BODY) && !next_s.tx.valid;
    next_s.busy = (next_s.st != ST_IDLE) || next_s.dist_act;
    // receive: strip address and protocol bytes, keep the space packet
    if (rx.valid)
    begin
      if (s.rx_idx != 4'hf)
        next_s.rx_idx = s.rx_idx + 4'h1;
      if (s.rx_idx == RX_IDX_PID)
        next_s.rx_keep = (rx.data == PTP_PID);                // R3
      if (s.rx_idx == RX_IDX_APIDH)
        next_s.apid_ok = (rx.data[2:0] == TIME_APID[10:8]);
      if (s.rx_idx == RX_IDX_APIDL)
        next_s.apid_ok = s.apid_ok && (rx.data == TIME_APID[7:0]);
      if (s.rx_idx >= RX_IDX_CUC && s.rx_idx <= RX_IDX_LAST)
        next_s.rx_cuc = cuc_in;
      if (s.rx_idx >= RX_IDX_BODY && s.rx_keep)
        next_s.dlv = '{valid: 1'b1, last: rx.last, data: rx.data}; // R5
      if (rx.last)
      begin
        next_s.rx_idx = 4'h0;
        next_s.rx_keep = 1'b0;
        next_s.apid_ok = 1'b0;
      end
    end
    // timecode zero or local command applies the held value
    if (tc_zero || apply_now)
    begin
      if (s.pend_v)
      begin
        next_s.time_reg = s.pend;                             // R8
        next_s.pend_v = 1'b0;
      end
      else if (tc_zero)
        next_s.time_reg = s.time_reg + TIME_STEP;  // extrapolate on a missed update
    end
    // a new value arriving with the apply still wins and stays held
    if (rx_cap)
    begin
      next_s.pend = cuc_in;                                   // R10
      next_s.pend_v = 1'b1;
    end
  end

  // single register of all state
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign src_ready    = s.src_ready;
  assign send_busy    = s.busy;
  assign tx           = s.tx;
  assign dlv          = s.dlv;
  assign time_now     = s.time_reg;
  assign time_pending = s.pend_v;

  property p_once;
    @(posedge clock) disable iff (!arst_n)
    (s.st == ST_BODY && s.src_ready && src.valid && src.last) |=> s.st == ST_IDLE;
  endproperty
  a_once: assert property (p_once) else $error("body did not end after last"); // R1

  property p_pid;
    @(posedge clock) disable iff (!arst_n)
    (s.st == ST_PID && free) |=> tx.valid && tx.data == PTP_PID;
  endproperty
  a_pid: assert property (p_pid) else $error("wrong protocol byte sent"); // R2

  property p_prefix;
    @(posedge clock) disable iff (!arst_n)
    (s.st == ST_IDLE && !s.dist_act && send_valid && send_req.path_len == 3'h0
     && !s.tx.valid) |=> ##1 tx.valid && tx.data == $past(send_req.laddr, 2);
  endproperty
  a_prefix: assert property (p_prefix) else $error("address byte not sent"); // R4

  property p_deliver;
    @(posedge clock) disable iff (!arst_n)
    (rx.valid && s.rx_keep && s.rx_idx >= RX_IDX_BODY) |=> dlv.valid
      && dlv.data == $past(rx.data);
  endproperty
  a_deliver: assert property (p_deliver) else $error("packet byte not delivered"); // R5

  property p_next_zero;
    @(posedge clock) disable iff (!arst_n)
    (dist_start && !s.dist_act) |=> s.frame == $past(s.time_reg) + TIME_STEP;
  endproperty
  a_next_zero: assert property (p_next_zero) else $error("time packet value wrong"); // R7

  property p_apply;
    @(posedge clock) disable iff (!arst_n)
    (tc_zero && s.pend_v && !rx_cap) |=> time_now == $past(s.pend) && !time_pending;
  endproperty
  a_apply: assert property (p_apply) else $error("held time not applied"); // R8

  property p_per_target;
    @(posedge clock) disable iff (!arst_n)
    (s.st == ST_TIME && free && s.tidx == 4'(TIME_BYTES - 1)
     && s.tgt != 8'(N_TARGETS - 1)) |=> ##1 s.st == ST_ADDR && s.is_time;
  endproperty
  a_per_target: assert property (p_per_target) else $error("target skipped"); // R9

  property p_latest;
    @(posedge clock) disable iff (!arst_n)
    rx_cap |=> time_pending && s.pend == $past(cuc_in);
  endproperty
  a_latest: assert property (p_latest) else $error("newest time not held"); // R10
endmodule

// File: rtl/ptps_pkg.sv
// Purpose: shared constants and carriers of the packet and time service node
// Assumes: one 50 MHz clock, byte-wide link streams from a link controller
// Notes:   time values are 6-byte unsegmented codes, 4 coarse and 2 fine bytes
package ptps_pkg;
  localparam int          CLK_HZ        = 50_000_000;   // system clock rate
  localparam int          PATH_MAX      = 4;            // most path bytes per send
  localparam int          CUC_BYTES     = 6;            // time value length
  localparam int          SP_HDR_BYTES  = 6;            // space packet primary header
  localparam int          TIME_BYTES    = SP_HDR_BYTES + CUC_BYTES; // time packet body
  localparam logic [7:0]  PTP_PID       = 8'h02;        // protocol byte of packet transfer
  localparam logic [10:0] TIME_APID     = 11'h07f;      // process id of time packets
  localparam logic [7:0]  SP_SEQ_HI     = 8'hc0;        // unsegmented, count 0
  localparam logic [15:0] SP_LEN_FIELD  = 16'h0005;     // data length minus one
  localparam logic [47:0] TIME_STEP     = 48'h0000_0040_0000; // time per timecode wrap
  localparam logic [3:0]  RX_IDX_PID    = 4'h1;         // rx byte of protocol id
  localparam logic [3:0]  RX_IDX_BODY   = 4'h2;         // first space packet byte
  localparam logic [3:0]  RX_IDX_APIDH  = 4'h2;         // apid high bits
  localparam logic [3:0]  RX_IDX_APIDL  = 4'h3;         // apid low bits
  localparam logic [3:0]  RX_IDX_CUC    = 4'h8;         // first time byte
  localparam logic [3:0]  RX_IDX_LAST   = 4'hd;         // last byte of a time packet
  localparam logic [5:0]  TC_ZERO       = 6'h00;        // timecode count that applies time

  // one stream byte; last marks the end of a packet
  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } ptps_byte_type;

  // send request from the upper layer
  typedef struct packed {
    logic [PATH_MAX-1:0][7:0] path;
    logic [2:0]               path_len;
    logic [7:0]               laddr;
  } ptps_req_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PATH = 3'b001,
    ST_ADDR = 3'b010,
    ST_PID  = 3'b011,
    ST_BODY = 3'b100,
    ST_TIME = 3'b101
  } ptps_st_type;

  // whole state of the node
  typedef struct packed {
    ptps_st_type   st;
    ptps_byte_type tx;
    logic          src_ready;
    logic          busy;
    ptps_req_type  req;
    logic [2:0]    pidx;
    logic          is_time;
    logic [3:0]    tidx;
    logic [7:0]    tgt;
    logic          dist_act;
    logic [47:0]   frame;
    logic [3:0]    rx_idx;
    logic          rx_keep;
    logic          apid_ok;
    logic [47:0]   rx_cuc;
    ptps_byte_type dlv;
    logic [47:0]   time_reg;
    logic [47:0]   pend;
    logic          pend_v;
  } ptps_state_type;
endpackage

// File: tb/ptps_link_model.sv
// Purpose: link controller beside the node, takes tx bytes with stalls
// Assumes: runs on the node clock
// Notes:   stall pattern comes from the bench; accepted bytes go back to it
module ptps_link_model
  import ptps_pkg::*;
(
  // clock and reset
  input  wire logic          clock,
  input  wire logic          arst_n,
  // node transmit stream
  input  wire ptps_byte_type tx,
  output logic               tx_ready,
  // stall request and accepted bytes
  input  wire logic          stall,
  output ptps_byte_type      got
);
  timeunit 1ns;
  timeprecision 1ns;

  // ready moves only at an edge, so each byte is taken exactly once
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_ready <= 1'b0;
      got      <= '0;
    end
    else
    begin
      tx_ready <= !stall;
      got      <= '{valid: tx.valid && tx_ready, last: tx.last, data: tx.data};
    end
  end
endmodule

// File: tb/ptps_node_tb_top.sv
// Purpose: self-checking bench of the packet and time service node
// Assumes: link model on tx, bench drives rx, timecodes and upper layer
// Notes:   expected bytes wait in queues until a monitor sees them
module ptps_node_tb_top;
  import ptps_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, arst_n, send_valid, tx_ready, tc_valid, dist_start, apply_now, stall;
  ptps_req_type  send_req;    // upper layer request
  ptps_byte_type src, tx, rx, dlv, got;
  logic          src_ready, send_busy, time_pending;
  logic [5:0]    tc_value;
  logic [1:0][7:0] targets;   // two time receivers
  logic [47:0]   time_now, texp, v;
  logic [47:0]   exp_tx[$], exp_dlv[$];  // expected link and delivered bytes
  logic [7:0]    pk[$], d[$];  // packet being built, source bytes
  logic [7:0]    lfsr = 8'h05;
  int            n_errors = 0, checked = 0, cyc = 0;
  logic [2:0]    plens[3] = '{3'h0, 3'h1, 3'h4};  // path lengths of the send scenarios

  ptps_node #(.N_TARGETS(2)) i_dut (.clock(clock), .arst_n(arst_n), .send_valid(send_valid),
    .send_req(send_req), .src(src), .src_ready(src_ready), .send_busy(send_busy), .tx(tx),
    .tx_ready(tx_ready), .rx(rx), .tc_valid(tc_valid), .tc_value(tc_value), .dlv(dlv),
    .dist_start(dist_start), .targets(targets), .apply_now(apply_now),
    .time_now(time_now), .time_pending(time_pending));
  ptps_link_model i_link (.clock(clock), .arst_n(arst_n), .tx(tx), .tx_ready(tx_ready),
    .stall(stall), .got(got));

  // pseudo random bytes, fixed start
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction

  task automatic summarize();
    if (n_errors == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // wait until all expected bytes arrived and the sender is idle
  task automatic wait_quiet();
    for (int t = 0; t < 600; t++)
    begin
      @(posedge clock);
      #1;
      if (exp_tx.size() == 0 && exp_dlv.size() == 0 && send_busy === 1'b0)
        return;
    end
    n_errors++;
    summarize();
  endtask

  // time packet: address, protocol, header on the time process id, value msb first
  task automatic mk_time(input logic [7:0] la, input logic [47:0] t);
    pk = '{la, PTP_PID, {5'h00, TIME_APID[10:8]}, TIME_APID[7:0], SP_SEQ_HI, 8'h00,
           SP_LEN_FIELD[15:8], SP_LEN_FIELD[7:0]};
    for (int i = 5; i >= 0; i--)
      pk.push_back(t[i*8 +: 8]);
  endtask

  // receive pk; bytes after the protocol id are due upstream when it matches
  task automatic rx_pkt();
    foreach (pk[i])
    begin
      if (i >= 2 && pk[1] == PTP_PID)
        exp_dlv.push_back(48'(pk[i]));
      @(posedge clock);
      #1 rx = '{valid: 1'b1, last: i == pk.size() - 1, data: pk[i]};
    end
    @(posedge clock);
    #1 rx = '0;
    wait_quiet();
  endtask

  // one send request: path, address, protocol id, then source bytes as is
  task automatic send(input logic [2:0] plen, input int n);
    ptps_req_type r;
    int k;
    logic tk;
    r = '0;
    for (int i = 0; i < PATH_MAX; i++)
      r.path[i] = rnd();
    r.path_len = plen;
    r.laddr = rnd();
    for (int i = 0; i < 32'(plen); i++)
      exp_tx.push_back(48'(r.path[i]));
    exp_tx.push_back(48'(r.laddr));
    exp_tx.push_back(48'(PTP_PID));
    d = {};
    for (int i = 0; i < n; i++)
    begin
      d.push_back(rnd());
      exp_tx.push_back(48'({i == n - 1, d[i]}));
    end
    @(posedge clock);
    #1 send_valid = 1'b1;
    send_req = r;
    src = '{valid: 1'b1, last: n == 1, data: d[0]};
    @(posedge clock);
    #1 send_valid = 1'b0;
    check(48'(send_busy), 48'h1);
    k = 0;
    for (int t = 0; t < 400 && k < n; t++)
    begin
      // ready read settled after an edge decides the take at the next edge
      tk = (src_ready === 1'b1);
      @(posedge clock);
      #1;
      if (tk)
        k++;
      src = (k < n) ? '{valid: 1'b1, last: k == n - 1, data: d[k]} : '0;
    end
    if (k < n)
    begin
      n_errors++;
      summarize();
    end
    wait_quiet();
  endtask

  // timecode or apply pulse, result read two edges later
  task automatic pulse(input logic tc, input logic [5:0] val);
    @(posedge clock);
    #1 tc_valid = tc;
    apply_now = !tc;
    tc_value = val;
    @(posedge clock);
    #1 tc_valid = 1'b0;
    apply_now = 1'b0;
    @(posedge clock);
    #1;
  endtask

  // link and delivery monitors compare against the oldest note
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    #1 stall = cyc[2] & cyc[0];
    if (got.valid === 1'b1)
      check(48'({got.last, got.data}), exp_tx.size() ? exp_tx.pop_front() : 'x);
    if (dlv.valid === 1'b1)
      check(48'(dlv.data), exp_dlv.size() ? exp_dlv.pop_front() : 'x);
  end

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  initial
  begin
    arst_n = 0; send_valid = 0; send_req = '0; src = '0; rx = '0; stall = 0;
    tc_valid = 0; tc_value = 6'h00; dist_start = 0; apply_now = 0; targets = '0;
    repeat (8) @(posedge clock);
    #1 arst_n = 1'b1;
    check(48'({tx, dlv, src_ready, send_busy}), 48'h0);
    check(time_now, 48'h0);
    check(48'(time_pending), 48'h0);
    foreach (plens[j])
      send(plens[j], j + 1);
    pk = '{8'h21, PTP_PID, 8'h11, 8'h22, 8'h33};
    rx_pkt();
    pk = '{8'h21, 8'h03, 8'h44, 8'h55};
    rx_pkt();
    mk_time(8'h30, {rnd(), rnd(), 32'h0});
    rx_pkt();
    v = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    mk_time(8'h30, v);
    rx_pkt();
    check(48'(time_pending), 48'h1);
    pulse(1'b1, 6'h05);
    check(time_now, 48'h0);
    pulse(1'b1, TC_ZERO);
    check(time_now, v);
    check(48'(time_pending), 48'h0);
    pulse(1'b1, TC_ZERO);
    texp = v + TIME_STEP;
    check(time_now, texp);
    v = {rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
    mk_time(8'h30, v);
    rx_pkt();
    pulse(1'b0, 6'h07);
    check(time_now, v);
    targets = {rnd(), rnd()};
    for (int k = 0; k < 2; k++)
    begin
      mk_time(targets[k], v + TIME_STEP);
      foreach (pk[i])
        exp_tx.push_back(48'({i == pk.size() - 1, pk[i]}));
    end
    @(posedge clock);
    #1 dist_start = 1'b1;
    // held over a second edge: a start inside a running round is ignored
    repeat (2) @(posedge clock);
    #1 dist_start = 1'b0;
    check(48'(send_busy), 48'h1);
    repeat (2) @(posedge clock);
    wait_quiet();
    summarize();
  end
endmodule
